// ===== verilog/svsc_top.sv
`timescale 1ns/1ps
// Behaviour
// - Comparator goes to the sense pin when both level enables are set.
// - Converter channel goes to the sense pin when both converter enables are set.
// - Writing sense converter enable as one clears supply converter enable.
// - Writing sense level enable as one clears supply level enable.
// - Supply converter enable sets only while sense converter enable is clear.
// - Supply level enable sets only while sense level enable is clear.
// - Bit 6 picks the first or second high threshold.
// - Bits 5:4 pick one of four low thresholds.
// - In run mode any enable of a pin closes its divider and function.
// - Stop mode opens both dividers and halts level sensing.
// - Stop mode leaves the configuration register unchanged.
// - Unimplemented bits and reserved offsets read as zero.
// - Result is invalid for settle time plus two cycles after enable change.
// - A flag sets whenever its condition status bit changes.
// - Flags clear only by writing one; zero has no effect.
// - Interrupt requested while any flag is set with its enable set.
// - In run mode both status bits are zero while both level enables are clear; stop mode holds them.
module svsc_top
    import svsc_pkg::*;
#(
    parameter int SETTLE_CYC = SVSC_SETTLE_CYC
) (
    input  wire logic        clk_sys_i,
    input  wire logic        arst_n_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic [31:0]      hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    input  wire logic        stop_mode_i,
    input  wire logic        high_cmp_raw_i,
    input  wire logic        low_cmp_raw_i,
    output logic             sense_divider_close_o,
    output logic             supply_divider_close_o,
    output logic             sense_to_converter_o,
    output logic             supply_to_converter_o,
    output logic             comparator_on_sense_o,
    output logic             comparator_on_supply_o,
    output logic             high_threshold_select_o,
    output logic [1:0]       low_threshold_select_o,
    output logic             result_valid_o,
    output logic             irq_o
);

    function automatic logic is_idx(input logic [31:0] addr, input logic [2:0] idx);
        return (addr[31:5] == 27'h0) && (addr[4:2] == idx);
    endfunction

    logic [6:0]  enable_q;
    logic [1:0]  status_q;
    logic [1:0]  status_d;
    logic [1:0]  irq_en_q;
    logic [1:0]  flags_q;
    logic [1:0]  flags_d;
    logic [1:0]  cmp_meta_q;
    logic [1:0]  cmp_sync_q;
    logic [31:0] addr_q;
    logic        wr_pend_q;
    logic        rd_pend_q;
    logic        addr_phase;
    logic        wr_en;
    logic [6:0]  enable_wr;
    logic [7:0]  settle_q;
    logic [31:0] rd_mux;

    // Bus: writes complete at the end of a zero-wait data phase
    assign addr_phase = hsel_i && hready_i && (htrans_i == SVSC_HTRANS_NONSEQ);
    assign wr_en      = wr_pend_q;

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            addr_q    <= 32'h0;
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
        end else begin
            wr_pend_q <= addr_phase && hwrite_i;
            rd_pend_q <= addr_phase && !hwrite_i;
            if (addr_phase) begin
                addr_q <= haddr_i;
            end
        end
    end

    // A read waits one cycle so that a write finishing just before is seen
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hreadyout_o <= 1'b1;
            hresp_o     <= SVSC_HRESP_OKAY;
            hrdata_o    <= 32'h0;
        end else begin
            hresp_o <= SVSC_HRESP_OKAY;
            if (addr_phase && !hwrite_i) begin
                hreadyout_o <= 1'b0;
            end else if (rd_pend_q && !hreadyout_o) begin
                hreadyout_o <= 1'b1;
                hrdata_o    <= rd_mux;
            end
        end
    end

    // Reserved offsets and unmapped addresses fall through to zero
    always_comb begin
        rd_mux = 32'h0;
        if (is_idx(addr_q, SVSC_IDX_ENABLE)) begin
            rd_mux = {25'h0, enable_q};
        end else if (is_idx(addr_q, SVSC_IDX_STATUS)) begin
            rd_mux = {30'h0, status_q};
        end else if (is_idx(addr_q, SVSC_IDX_IRQ_EN)) begin
            rd_mux = {30'h0, irq_en_q};
        end else if (is_idx(addr_q, SVSC_IDX_FLAGS)) begin
            rd_mux = {30'h0, flags_q};
        end
    end

    // Enable register write value with the mutual exclusion of the pin pairs
    always_comb begin
        enable_wr = hwdata_i[6:0];
        enable_wr[SVSC_SUPPLY_CONV_BIT] = hwdata_i[SVSC_SUPPLY_CONV_BIT]
            && !hwdata_i[SVSC_SENSE_CONV_BIT]
            && !enable_q[SVSC_SENSE_CONV_BIT];
        enable_wr[SVSC_SUPPLY_LVL_BIT] = hwdata_i[SVSC_SUPPLY_LVL_BIT]
            && !hwdata_i[SVSC_SENSE_LVL_BIT]
            && !enable_q[SVSC_SENSE_LVL_BIT];
    end

    // Stop mode does not touch the configuration
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            enable_q <= SVSC_ENABLE_RST;
            irq_en_q <= SVSC_PAIR_RST;
        end else if (wr_en) begin
            if (is_idx(addr_q, SVSC_IDX_ENABLE)) begin
                enable_q <= enable_wr;
            end
            if (is_idx(addr_q, SVSC_IDX_IRQ_EN)) begin
                irq_en_q <= hwdata_i[1:0];
            end
        end
    end

    // Analogue path controls
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sense_divider_close_o   <= 1'b0;
            supply_divider_close_o  <= 1'b0;
            sense_to_converter_o    <= 1'b0;
            supply_to_converter_o   <= 1'b0;
            comparator_on_sense_o   <= 1'b0;
            comparator_on_supply_o  <= 1'b0;
            high_threshold_select_o <= 1'b0;
            low_threshold_select_o  <= 2'h0;
        end else begin
            sense_divider_close_o  <= !stop_mode_i
                && (enable_q[SVSC_SENSE_LVL_BIT] || enable_q[SVSC_SENSE_CONV_BIT]);
            supply_divider_close_o <= !stop_mode_i
                && (enable_q[SVSC_SUPPLY_LVL_BIT] || enable_q[SVSC_SUPPLY_CONV_BIT]);
            sense_to_converter_o   <= !stop_mode_i && enable_q[SVSC_SENSE_CONV_BIT];
            supply_to_converter_o  <= !stop_mode_i && enable_q[SVSC_SUPPLY_CONV_BIT]
                && !enable_q[SVSC_SENSE_CONV_BIT];
            comparator_on_sense_o  <= !stop_mode_i && enable_q[SVSC_SENSE_LVL_BIT];
            comparator_on_supply_o <= !stop_mode_i && enable_q[SVSC_SUPPLY_LVL_BIT]
                && !enable_q[SVSC_SENSE_LVL_BIT];
            high_threshold_select_o <= enable_q[SVSC_HIGH_SEL_BIT];
            low_threshold_select_o  <= enable_q[SVSC_LOW_SEL_LSB +: 2];
        end
    end

    // Settling window after any change of the four path enables
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            settle_q       <= 8'h0;
            result_valid_o <= 1'b1;
        end else begin
            if (wr_en && is_idx(addr_q, SVSC_IDX_ENABLE) && (enable_wr[3:0] != enable_q[3:0])) begin
                settle_q       <= 8'(SETTLE_CYC);
                result_valid_o <= 1'b0;
            end else if (settle_q != 8'h0) begin
                settle_q       <= settle_q - 8'h1;
                result_valid_o <= (settle_q == 8'h1);
            end
        end
    end

    // Comparator outputs are asynchronous to the bus clock
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cmp_meta_q <= 2'h0;
            cmp_sync_q <= 2'h0;
        end else begin
            cmp_meta_q <= {high_cmp_raw_i, low_cmp_raw_i};
            cmp_sync_q <= cmp_meta_q;
        end
    end

    // Status holds in stop so that stop entry raises no flag
    always_comb begin
        status_d = status_q;
        if (!stop_mode_i) begin
            if (enable_q[SVSC_SENSE_LVL_BIT] || enable_q[SVSC_SUPPLY_LVL_BIT]) begin
                status_d = cmp_sync_q;
            end else begin
                status_d = 2'h0;
            end
        end
    end

    // Set wins over a simultaneous write-one clear
    always_comb begin
        flags_d = flags_q;
        if (wr_en && is_idx(addr_q, SVSC_IDX_FLAGS)) begin
            flags_d = flags_q & ~hwdata_i[1:0];
        end
        flags_d = flags_d | (status_d ^ status_q);
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            status_q <= SVSC_PAIR_RST;
            flags_q  <= SVSC_PAIR_RST;
        end else begin
            status_q <= status_d;
            flags_q  <= flags_d;
        end
    end

    // Interrupt computed from next-state values so it tracks the registers exactly
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_o <= 1'b0;
        end else if (wr_en && is_idx(addr_q, SVSC_IDX_IRQ_EN)) begin
            irq_o <= |(flags_d & hwdata_i[1:0]);
        end else begin
            irq_o <= |(flags_d & irq_en_q);
        end
    end

    sequence s_enable_write(int b);
        wr_en && is_idx(addr_q, SVSC_IDX_ENABLE) && hwdata_i[b];
    endsequence

    sequence s_settling;
        !result_valid_o [*2];
    endsequence

    a_cmp_one_pin: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        !stop_mode_i && enable_q[SVSC_SENSE_LVL_BIT] |=> comparator_on_sense_o && !comparator_on_supply_o)
        else $error("comparator not on sense pin");

    a_conv_one_pin: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        !stop_mode_i && enable_q[SVSC_SENSE_CONV_BIT] |=> sense_to_converter_o && !supply_to_converter_o)
        else $error("converter not on sense pin");

    a_conv_clear: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        s_enable_write(SVSC_SENSE_CONV_BIT) |=> !enable_q[SVSC_SUPPLY_CONV_BIT])
        else $error("supply converter enable not cleared");

    a_lvl_clear: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        s_enable_write(SVSC_SENSE_LVL_BIT) |=> !enable_q[SVSC_SUPPLY_LVL_BIT])
        else $error("supply level enable not cleared");

    a_conv_gate: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        $rose(enable_q[SVSC_SUPPLY_CONV_BIT]) |-> !$past(enable_q[SVSC_SENSE_CONV_BIT]))
        else $error("supply converter enable set against sense");

    a_lvl_gate: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        $rose(enable_q[SVSC_SUPPLY_LVL_BIT]) |-> !$past(enable_q[SVSC_SENSE_LVL_BIT]))
        else $error("supply level enable set against sense");

    a_thresh_sel: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        ##1 (high_threshold_select_o == $past(enable_q[6])) && (low_threshold_select_o == $past(enable_q[5:4])))
        else $error("threshold select mismatch");

    a_run_close: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        !stop_mode_i && (enable_q[0] || enable_q[1]) |=> sense_divider_close_o)
        else $error("sense divider not closed");

    a_stop_open: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        stop_mode_i |=> !sense_divider_close_o && !supply_divider_close_o && !comparator_on_sense_o)
        else $error("divider closed in stop");

    a_stop_keeps: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        stop_mode_i && !wr_en |=> $stable(enable_q))
        else $error("configuration changed in stop");

    a_rd_upper_zero: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        hrdata_o[31:7] == 25'h0)
        else $error("unimplemented bits read nonzero");

    a_settle_window: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        wr_en && is_idx(addr_q, SVSC_IDX_ENABLE) && (enable_wr[3:0] != enable_q[3:0]) |=> s_settling)
        else $error("result valid during settling");

    a_flag_set: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        ##1 $changed(status_q) |-> ((flags_q & (status_q ^ $past(status_q))) == (status_q ^ $past(status_q))))
        else $error("flag not set on status change");

    a_flag_keep: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        flags_q[0] && !(wr_en && is_idx(addr_q, SVSC_IDX_FLAGS) && hwdata_i[0]) |=> flags_q[0])
        else $error("flag lost without clear");

    a_irq_level: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        irq_o == |(flags_q & irq_en_q))
        else $error("interrupt output mismatch");

    a_status_off: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        !stop_mode_i && !enable_q[0] && !enable_q[2] |=> status_q == 2'h0)
        else $error("status not forced to zero");

    a_sync_depth: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        ##3 $past(enable_q[0]) && !$past(stop_mode_i) && $stable(enable_q[0])
        |-> status_q[SVSC_HIGH_BIT] == $past(high_cmp_raw_i, 3))
        else $error("status not from synchronised comparator");

    // Cycles since the last change of a path enable, saturating; zero until the first change
    logic        path_change;
    logic [8:0]  since_change_q;

    assign path_change = wr_en && is_idx(addr_q, SVSC_IDX_ENABLE) && (enable_wr[3:0] != enable_q[3:0]);

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            since_change_q <= 9'h0;
        end else if (path_change) begin
            since_change_q <= 9'h1;
        end else if ((since_change_q != 9'h0) && (since_change_q != 9'h1ff)) begin
            since_change_q <= since_change_q + 9'h1;
        end
    end

    sequence s_read_wait;
        !hreadyout_o ##1 hreadyout_o;
    endsequence

    a_settle_held: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (since_change_q != 9'h0) && (int'(since_change_q) <= SETTLE_CYC) |-> !result_valid_o)
        else $error("result valid inside settling window");

    a_settle_ends: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (int'(since_change_q) > SETTLE_CYC) || (since_change_q == 9'h0) |-> result_valid_o)
        else $error("result invalid outside settling window");

    a_cmp_supply_only: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        !stop_mode_i && enable_q[SVSC_SUPPLY_LVL_BIT] && !enable_q[SVSC_SENSE_LVL_BIT]
        |=> comparator_on_supply_o && !comparator_on_sense_o)
        else $error("comparator not on supply pin");

    a_conv_supply_only: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        !stop_mode_i && enable_q[SVSC_SUPPLY_CONV_BIT] && !enable_q[SVSC_SENSE_CONV_BIT]
        |=> supply_to_converter_o && !sense_to_converter_o)
        else $error("converter not on supply pin");

    a_supply_close: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        !stop_mode_i && (enable_q[SVSC_SUPPLY_LVL_BIT] || enable_q[SVSC_SUPPLY_CONV_BIT]) |=> supply_divider_close_o)
        else $error("supply divider not closed");

    a_idle_open: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        !enable_q[SVSC_SENSE_LVL_BIT] && !enable_q[SVSC_SENSE_CONV_BIT] |=> !sense_divider_close_o)
        else $error("sense divider closed without enable");

    a_stop_paths: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        stop_mode_i |=> !sense_to_converter_o && !supply_to_converter_o && !comparator_on_supply_o)
        else $error("path connected in stop");

    a_stop_status: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        stop_mode_i |=> $stable(status_q))
        else $error("status moved in stop");

    a_flag_keep_high: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        flags_q[SVSC_HIGH_BIT] && !(wr_en && is_idx(addr_q, SVSC_IDX_FLAGS) && hwdata_i[SVSC_HIGH_BIT])
        |=> flags_q[SVSC_HIGH_BIT])
        else $error("high flag lost without clear");

    a_flag_clear: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        wr_en && is_idx(addr_q, SVSC_IDX_FLAGS) && hwdata_i[SVSC_LOW_BIT]
        |=> !flags_q[SVSC_LOW_BIT] || $changed(status_q[SVSC_LOW_BIT]))
        else $error("low flag not cleared by write one");

    a_rsvd_zero: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        addr_phase && !hwrite_i && (haddr_i[4:2] > SVSC_IDX_FLAGS) |=> s_read_wait ##0 (hrdata_o == 32'h0))
        else $error("reserved offset read nonzero");

endmodule

// ===== verilog/svsc_pkg.sv
package svsc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [2:0] SVSC_IDX_ENABLE = 3'h0;
    localparam logic [2:0] SVSC_IDX_STATUS = 3'h1;
    localparam logic [2:0] SVSC_IDX_IRQ_EN = 3'h2;
    localparam logic [2:0] SVSC_IDX_FLAGS  = 3'h3;
    localparam logic [2:0] SVSC_IDX_RSVD_A = 3'h4;
    localparam logic [2:0] SVSC_IDX_RSVD_B = 3'h6;

    // Enable register fields
    localparam int SVSC_SENSE_LVL_BIT   = 0;
    localparam int SVSC_SENSE_CONV_BIT  = 1;
    localparam int SVSC_SUPPLY_LVL_BIT  = 2;
    localparam int SVSC_SUPPLY_CONV_BIT = 3;
    localparam int SVSC_LOW_SEL_LSB     = 4;
    localparam int SVSC_HIGH_SEL_BIT    = 6;

    // Status, irq enable and flag fields share one layout
    localparam int SVSC_LOW_BIT  = 0;
    localparam int SVSC_HIGH_BIT = 1;

    // Reset values
    localparam logic [6:0] SVSC_ENABLE_RST = 7'h00;
    localparam logic [1:0] SVSC_PAIR_RST   = 2'h0;

    // Timing
    localparam int SVSC_CLK_PERIOD_NS  = 25;
    localparam int SVSC_SETTLE_TIME_NS = 1000;
    localparam int SVSC_SETTLE_EXTRA   = 2;
    localparam int SVSC_SETTLE_CYC     =
        (SVSC_SETTLE_TIME_NS + SVSC_CLK_PERIOD_NS - 1) / SVSC_CLK_PERIOD_NS + SVSC_SETTLE_EXTRA;

    // AHB-Lite encodings
    localparam logic [1:0] SVSC_HTRANS_NONSEQ = 2'h2;
    localparam logic       SVSC_HRESP_OKAY    = 1'b0;
endpackage

// ===== bench/svsc_analog_model.sv
`timescale 1ns/1ps
// Comparator pair behind the divider multiplexer, levels in arbitrary units
module svsc_analog_model (
    input  wire logic       clk_i,
    input  wire logic       on_sense_i,
    input  wire logic       on_supply_i,
    input  wire logic       high_sel_i,
    input  wire logic [1:0] low_sel_i,
    input  wire logic [7:0] sense_lvl_i,
    input  wire logic [7:0] supply_lvl_i,
    output logic            high_raw_o,
    output logic            low_raw_o
);
    logic [7:0] lvl;
    logic       junk_q = 1'b0;
    assign lvl = on_sense_i ? sense_lvl_i : supply_lvl_i;
    // A disconnected comparator is not trusted, so its output wanders
    always @(posedge clk_i) junk_q <= ~junk_q;
    always @* begin
        if (on_sense_i || on_supply_i) begin
            high_raw_o = lvl >= (high_sel_i ? 8'hc8 : 8'hb4);
            low_raw_o  = lvl < (8'h32 + {3'h0, low_sel_i, 3'h0});
        end else begin
            high_raw_o = junk_q;
            low_raw_o  = ~junk_q;
        end
    end
endmodule

// ===== bench/tb.sv
`timescale 1ns/1ps
module tb;
    import svsc_pkg::*;
    localparam int SETTLE = 4;
    logic        clk_sys_i = 1'b0;
    logic        arst_n_i  = 1'b0;
    logic        hsel      = 1'b0;
    logic [31:0] haddr     = 32'h0;
    logic [1:0]  htrans    = 2'h0;
    logic        hwrite    = 1'b0;
    logic [31:0] hwdata    = 32'h0;
    logic        stop      = 1'b0;
    logic [7:0]  sense_mv  = 8'h64;
    logic [7:0]  supply_mv = 8'h64;
    logic [6:0]  en_model  = 7'h00;
    logic [31:0] hrdata, rd, wd;
    logic        hready, hresp, hraw, lraw, irq, rvalid;
    logic [8:0]  outs;
    logic [6:0]  old;
    logic [31:0] table_q [6] = '{32'h3, 32'hc, 32'hf, 32'h0, 32'hc, 32'h3};
    integer      seed = 32'hfb0c;
    integer      failures = 0;
    integer      checked = 0;

    svsc_top #(.SETTLE_CYC(SETTLE)) dut (
        .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
        .hreadyout_o(hready), .hresp_o(hresp), .stop_mode_i(stop), .high_cmp_raw_i(hraw),
        .low_cmp_raw_i(lraw), .sense_divider_close_o(outs[8]), .supply_divider_close_o(outs[7]),
        .sense_to_converter_o(outs[6]), .supply_to_converter_o(outs[5]), .comparator_on_sense_o(outs[4]),
        .comparator_on_supply_o(outs[3]), .high_threshold_select_o(outs[2]),
        .low_threshold_select_o(outs[1:0]), .result_valid_o(rvalid), .irq_o(irq));

    svsc_analog_model model (
        .clk_i(clk_sys_i), .on_sense_i(outs[4]), .on_supply_i(outs[3]), .high_sel_i(outs[2]),
        .low_sel_i(outs[1:0]), .sense_lvl_i(sense_mv), .supply_lvl_i(supply_mv),
        .high_raw_o(hraw), .low_raw_o(lraw));

    function automatic logic [6:0] next_en(input logic [6:0] cur, input logic [31:0] w);
        next_en    = w[6:0];
        next_en[3] = w[3] & ~w[1] & ~cur[1];
        next_en[2] = w[2] & ~w[0] & ~cur[0];
    endfunction

    function automatic logic [8:0] exp_outs(input logic [6:0] e, input logic s);
        exp_outs = {~s & (e[0] | e[1]), ~s & (e[2] | e[3]), ~s & e[1], ~s & e[3] & ~e[1],
                    ~s & e[0], ~s & e[2] & ~e[0], e[6], e[5:4]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Master waits on hready with no assumed latency; only the watchdog ends a hang
    task automatic bus(input logic w, input logic [2:0] idx, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {27'h0, idx, 2'h0};
        htrans <= SVSC_HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge clk_sys_i); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys_i); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rdchk(input logic [2:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0);
        check(rd, exp);
        check(hresp, SVSC_HRESP_OKAY);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic finish_test();
        if (failures == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    initial begin
        repeat (5000) @(posedge clk_sys_i);
        failures++;
        finish_test();
    end

    initial begin
        repeat (2) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        @(posedge clk_sys_i);
        for (int i = 0; i < 8; i++) begin
            rdchk(i[2:0], 32'h0);
        end
        bus(1'b1, SVSC_IDX_RSVD_A, 32'hff);
        rdchk(SVSC_IDX_RSVD_A, 32'h0);
        // Corner table first, then random words with upper bits set
        for (int i = 0; i < 20; i++) begin
            wd = (i < 6) ? table_q[i] : $random(seed);
            old = en_model;
            bus(1'b1, SVSC_IDX_ENABLE, wd);
            en_model = next_en(en_model, wd);
            settle(1);
            check(rvalid, old[3:0] == en_model[3:0]);
            settle(1);
            check(rvalid, old[3:0] == en_model[3:0]);
            check(outs, exp_outs(en_model, 1'b0));
            rdchk(SVSC_IDX_ENABLE, {25'h0, en_model});
            settle(SETTLE + 2);
            check(rvalid, 1'b1);
        end
        bus(1'b1, SVSC_IDX_ENABLE, 32'h1);
        settle(12);
        bus(1'b1, SVSC_IDX_FLAGS, 32'h3);
        bus(1'b1, SVSC_IDX_IRQ_EN, 32'h3);
        rdchk(SVSC_IDX_FLAGS, 32'h0);
        check(irq, 1'b0);
        sense_mv <= 8'hc8;
        settle(8);
        rdchk(SVSC_IDX_STATUS, 32'h2);
        rdchk(SVSC_IDX_FLAGS, 32'h2);
        check(irq, 1'b1);
        bus(1'b1, SVSC_IDX_FLAGS, 32'h0);
        rdchk(SVSC_IDX_FLAGS, 32'h2);
        bus(1'b1, SVSC_IDX_IRQ_EN, 32'h1);
        settle(2);
        check(irq, 1'b0);
        bus(1'b1, SVSC_IDX_FLAGS, 32'h2);
        rdchk(SVSC_IDX_FLAGS, 32'h0);
        sense_mv <= 8'h14;
        settle(8);
        rdchk(SVSC_IDX_STATUS, 32'h1);
        rdchk(SVSC_IDX_FLAGS, 32'h3);
        check(irq, 1'b1);
        bus(1'b1, SVSC_IDX_IRQ_EN, 32'h0);
        bus(1'b1, SVSC_IDX_ENABLE, 32'h0);
        settle(8);
        rdchk(SVSC_IDX_STATUS, 32'h0);
        bus(1'b1, SVSC_IDX_ENABLE, 32'hf);
        stop <= 1'b1;
        settle(3);
        check(outs, exp_outs(7'h03, 1'b1));
        rdchk(SVSC_IDX_ENABLE, 32'h3);
        stop <= 1'b0;
        settle(3);
        check(outs, exp_outs(7'h03, 1'b0));
        finish_test();
    end
endmodule
